// *** tb/beel_error_log_bench.sv ***
// Self-checking bench for the bus interface error log.
// Assumes one clock; the partner model answers the grant path.
module beel_error_log_bench
  import beel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    beel_kind_type k;
    logic [5:0] f;
    logic [5:0] s;
    logic [7:0] st;
    logic irq;
  } beel_case_type;
  localparam logic [21:0] BA = 22'h3A_5C00;
  logic clk_in = 1'b0, rst_in = 1'b1, dcok_in = 1'b1, io_rst = 1'b0;
  logic reg_rd = 1'b0, reg_wr = 1'b0, irq_ack = 1'b0, arb_req = 1'b0;
  logic answer = 1'b1, slow = 1'b0, sack, grant, reg_ack, ip_err;
  logic [31:0] reg_addr = '0, reg_wdata = '0, reg_rdata, v;
  logic [3:0] reg_be = 4'hF;
  logic [5:0] seen = '0;
  beel_evt_type evt = '0;
  beel_resp_type resp;
  int failures = 0, checked = 0, hi;
  beel_case_type cases [9] = '{
    '{BEEL_K_DMA_WR, 6'h08, 6'h00, 8'h01, 1'b1},
    '{BEEL_K_DMA_RD, 6'h10, 6'h30, 8'h10, 1'b0},
    '{BEEL_K_DMA_WR, 6'h10, 6'h00, 8'h10, 1'b1},
    '{BEEL_K_MAP_WR, 6'h08, 6'h00, 8'h01, 1'b1},
    '{BEEL_K_MAP_RD, 6'h10, 6'h03, 8'h00, 1'b0},
    '{BEEL_K_LMGH_RD, 6'h10, 6'h03, 8'h10, 1'b0},
    '{BEEL_K_LMGH_WR, 6'h08, 6'h00, 8'h01, 1'b1},
    '{BEEL_K_LOCK, 6'h10, 6'h0F, 8'h00, 1'b0},
    '{BEEL_K_WRITE, 6'h04, 6'h03, 8'h00, 1'b0}
  };
  // Clock, 10 ns period
  always #5 clk_in = ~clk_in;
  // Collect one-cycle response pulses
  always @(posedge clk_in)
    seen <= seen | {resp.bus_data_lines_par, resp.bus_release, resp.lock_release,
      resp.mcheck, resp.abort};
  beel_error_log #(.GRANT_CYC(50)) i_beel_error_log (.clk_in(clk_in), .rst_in(rst_in),
    .dcok_in(dcok_in), .io_reset_register_write_in(io_rst), .reg_addr_in(reg_addr),
    .reg_rd_in(reg_rd), .reg_wr_in(reg_wr), .reg_be_in(reg_be), .reg_wdata_in(reg_wdata),
    .reg_rdata_out(reg_rdata), .reg_ack_out(reg_ack), .evt_in(evt), .irq_ack_in(irq_ack),
    .resp_out(resp), .interprocessor_register_mem_err_out(ip_err), .arb_req_in(arb_req),
    .sack_in(sack), .grant_out(grant));
  beel_partner i_beel_partner (.clk_in(clk_in), .grant_in(grant), .answer_in(answer),
    .slow_in(slow), .sack_out(sack));
  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    checked++;
    if (seen_v !== exp_v)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  // One register access, strobe for one cycle, bounded wait for ack
  task automatic reg_op(input logic wr, input logic [31:0] a, input logic [3:0] be,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    reg_rd <= !wr;
    reg_wr <= wr;
    reg_addr <= a;
    reg_be <= be;
    reg_wdata <= d;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    q = 'x;
    for (int i = 0; i < 3; i++)
    begin
      #1;
      if (reg_ack === 1'b1)
      begin
        q = reg_rdata;
        break;
      end
      @(posedge clk_in);
    end
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp_v);
    logic [31:0] q;
    reg_op(1'b0, a, 4'hF, 32'h0, q);
    check(q, exp_v);
  endtask
  function automatic beel_evt_type ev(beel_kind_type k, logic [5:0] f, logic [28:0] ma);
    ev = '0;
    ev.kind = k;
    {ev.parity, ev.mem_err, ev.nxm, ev.multi_lw, ev.wait_resp, ev.wait_grant} = f;
    ev.bus_addr = BA;
    ev.map_addr = ma;
  endfunction
  // Present an event for n cycles, then let responses land
  task automatic hold(input beel_evt_type e, input int n);
    #1;
    seen = '0;
    @(posedge clk_in);
    evt <= e;
    repeat (n) @(posedge clk_in);
    evt <= '0;
    repeat (3) @(posedge clk_in);
  endtask
  // Clear whole status byte and any pending interrupt
  task automatic clear_all();
    reg_op(1'b1, BEEL_ADDR_STATUS, 4'h1, 32'hFF, v);
    @(posedge clk_in);
    irq_ack <= 1'b1;
    @(posedge clk_in);
    irq_ack <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  // Length of the next grant pulse in cycles
  task automatic grant_len(output int n);
    n = 0;
    for (int i = 0; i < 20 && grant !== 1'b1; i++) @(posedge clk_in);
    while (grant === 1'b1 && n < 1200)
    begin
      @(posedge clk_in);
      n++;
    end
  endtask
  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog: run needs under 10000 cycles
  initial
  begin
    #200000;
    failures++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rd_chk(BEEL_ADDR_STATUS, 32'h0);
    rd_chk(32'h2008_0040, 32'h0);
    $display("Test reset done");
    hold(ev(BEEL_K_DEMAND, 6'h20, 29'h0), 1);
    check({26'h0, seen}, 32'h3);
    rd_chk(BEEL_ADDR_STATUS, 32'h20);
    rd_chk(BEEL_ADDR_MPAGE, {19'h0, BA[21:9]});
    hold(ev(BEEL_K_DEMAND, 6'h20, 29'h0) ^ (22'h1 << 40), 1);
    reg_op(1'b0, BEEL_ADDR_STATUS, 4'h3, 32'h0, v);
    check(v, 32'h28);
    rd_chk(BEEL_ADDR_MPAGE, {19'h0, BA[21:9]});
    hold(ev(BEEL_K_PREFETCH, 6'h20, 29'h0), 1);
    check({26'h0, seen}, 32'h1);
    reg_op(1'b1, BEEL_ADDR_STATUS, 4'h1, 32'h0, v);
    rd_chk(BEEL_ADDR_STATUS, 32'h28);
    reg_op(1'b1, BEEL_ADDR_STATUS, 4'h1, 32'h28, v);
    rd_chk(BEEL_ADDR_STATUS, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      #1;
      seen = '0;
      reg_op(1'b1, i ? BEEL_ADDR_SPAGE : BEEL_ADDR_MPAGE, 4'hF, 32'hFFFF_FFFF, v);
      repeat (2) @(posedge clk_in);
      check({26'h0, seen}, 32'h2);
    end
    $display("Test master log done");
    foreach (cases[i])
    begin
      hold(ev(cases[i].k, cases[i].f, 29'h1ABC_0000 + (i << 9)), 1);
      check({26'h0, seen}, {26'h0, cases[i].s});
      rd_chk(BEEL_ADDR_STATUS, {24'h0, cases[i].st});
      check({31'h0, resp.irq_req}, {31'h0, cases[i].irq});
      check({18'h0, resp.irq_level, resp.irq_vector}, {18'h0, 5'h1D, 9'h060});
      check({31'h0, ip_err}, {31'h0, |cases[i].st});
      if (cases[i].st != 8'h0)
        rd_chk(BEEL_ADDR_SPAGE, {12'h0, 8'hD5, i[11:0] + 12'hE00});
      if (i == 0)
      begin
        hold(ev(BEEL_K_DMA_WR, 6'h10, 29'h0), 1);
        rd_chk(BEEL_ADDR_SPAGE, 32'h000D_5E00);
        rd_chk(BEEL_ADDR_STATUS, 32'h19);
      end
      clear_all();
      check({30'h0, resp.irq_req, ip_err}, 32'h0);
    end
    $display("Test slave cases done");
    hold(ev(BEEL_K_PREFETCH, 6'h02, 29'h0), 990);
    check({26'h0, seen}, 32'h0);
    hold(ev(BEEL_K_PREFETCH, 6'h02, 29'h0), 1005);
    check({26'h0, seen}, 32'h1);
    rd_chk(BEEL_ADDR_STATUS, 32'h0);
    hold(ev(BEEL_K_VECTOR, 6'h02, 29'h0), 1005);
    check({26'h0, seen}, 32'h1);
    hold(ev(BEEL_K_DEMAND, 6'h02, 29'h0), 1005);
    check({26'h0, seen}, 32'h3);
    rd_chk(BEEL_ADDR_STATUS, 32'h80);
    rd_chk(BEEL_ADDR_MPAGE, {19'h0, BA[21:9]});
    clear_all();
    hold(ev(BEEL_K_WRITE, 6'h02, 29'h0), 990);
    check({31'h0, resp.irq_req}, 32'h0);
    hold(ev(BEEL_K_WRITE, 6'h02, 29'h0), 1005);
    check({31'h0, resp.irq_req}, 32'h1);
    rd_chk(BEEL_ADDR_STATUS, 32'h80);
    clear_all();
    hold(ev(BEEL_K_DEMAND, 6'h01, 29'h0), 45);
    check({26'h0, seen}, 32'h0);
    hold(ev(BEEL_K_DEMAND, 6'h01, 29'h0), 55);
    check({26'h0, seen}, 32'h3);
    rd_chk(BEEL_ADDR_STATUS, 32'h04);
    @(posedge clk_in);
    io_rst <= 1'b1;
    @(posedge clk_in);
    io_rst <= 1'b0;
    rd_chk(BEEL_ADDR_STATUS, 32'h0);
    hold(ev(BEEL_K_DEMAND, 6'h20, 29'h0), 1);
    dcok_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    dcok_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd_chk(BEEL_ADDR_STATUS, 32'h0);
    $display("Test timeouts done");
    arb_req <= 1'b1;
    grant_len(hi);
    check({31'h0, hi >= 3 && hi < 12}, 32'h1);
    slow <= 1'b1;
    grant_len(hi);
    check({31'h0, hi > 890 && hi < 1000}, 32'h1);
    answer <= 1'b0;
    grant_len(hi);
    check({31'h0, hi >= 998 && hi <= 1002}, 32'h1);
    hi = 0;
    while (grant !== 1'b1 && hi < 100)
    begin
      @(posedge clk_in);
      hi++;
    end
    check({31'h0, hi >= 49 && hi <= 52}, 32'h1);
    arb_req <= 1'b0;
    rd_chk(BEEL_ADDR_STATUS, 32'h0);
    $display("Test arbiter done");
    complete_run();
  end
endmodule // beel_error_log_bench

// *** tb/beel_partner.sv ***
// Far-side bus master model: answers a grant with an acknowledge.
// Assumes grant_in comes straight from the arbiter on the same clock.
module beel_partner (
  // Clock
  input wire logic clk_in,
  // Grant path
  input wire logic grant_in,
  input wire logic answer_in,
  input wire logic slow_in,
  output logic sack_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt = 0;
  initial sack_out = 1'b0;
  // Acknowledge on the 4th or 901st granted cycle, hold tenure 9 cycles, then release
  always @(posedge clk_in)
  begin
    if (sack_out)
    begin
      cnt <= cnt + 1;
      if (cnt == 8)
      begin
        sack_out <= 1'b0; // Released pin reads idle low
        cnt <= 0;
      end
    end
    else if (grant_in && answer_in)
    begin
      cnt <= cnt + 1;
      if (cnt == (slow_in ? 900 : 3))
      begin
        sack_out <= 1'b1;
        cnt <= 0;
      end
    end
    else
      cnt <= 0;
  end
endmodule // beel_partner

// *** verilog/beel_error_log.sv ***
// Error detection, logging and reporting for the system bus interface.
// Assumes error strobes and register strobes on clk_in; DCOK and the
// bus acknowledge are pins and are synchronised here.
module beel_error_log
  import beel_pkg::*;
#(
  parameter int GRANT_CYC = BEEL_GRANT_CYC
)(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic dcok_in,
  input wire logic io_reset_register_write_in,
  // Local processor register port
  input wire logic [31:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [3:0] reg_be_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_ack_out,
  // Error strobes and responses
  input wire beel_evt_type evt_in,
  input wire logic irq_ack_in,
  output beel_resp_type resp_out,
  output logic interprocessor_register_mem_err_out,
  // Arbiter grant path
  input wire logic arb_req_in,
  input wire logic sack_in,
  output logic grant_out
);

  typedef struct packed {
    logic dcok_s1;
    logic dcok_s2;
    logic sack_s1;
    logic sack_s2;
    logic [BEEL_ST_W-1:0] status;
    logic [BEEL_MPAGE_W-1:0] mpage;
    logic [BEEL_SPAGE_W-1:0] spage;
    logic ip_mem_err;
    logic [BEEL_TMR_W-1:0] resp_cnt;
    logic [BEEL_TMR_W-1:0] grant_cnt;
    beel_arb_type arb;
    logic [BEEL_ARB_W-1:0] arb_cnt;
    beel_resp_type resp;
    logic [31:0] rdata;
    logic ack;
  } beel_state_type;

  beel_state_type r;
  beel_state_type next_r;

  // Kinds whose slave errors are logged into the slave page
  function automatic logic slave_logs(input beel_kind_type k);
    slave_logs = (k == BEEL_K_MAP_WR) || (k == BEEL_K_DMA_RD) || (k == BEEL_K_DMA_WR) ||
                 (k == BEEL_K_LMGH_RD) || (k == BEEL_K_LMGH_WR);
  endfunction

  // Address match for the register port
  function automatic logic hit(input logic [31:0] a, input logic [31:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  logic clr_all;
  logic resp_to;
  logic grant_to;
  logic m_evt;
  logic m_capture;
  logic s_evt;
  logic [BEEL_ST_W-1:0] set_bits;
  logic [BEEL_ST_W-1:0] clr_bits;
  logic do_abort;
  logic do_mcheck;
  logic do_irq;

  // Next state
  always_comb
  begin
    next_r = r;
    set_bits = '0;
    clr_bits = '0;
    do_abort = 1'b0;
    do_mcheck = 1'b0;
    do_irq = 1'b0;
    m_evt = 1'b0;
    m_capture = 1'b0;
    s_evt = 1'b0;
    // Pin synchronisers
    next_r.dcok_s1 = dcok_in;
    next_r.dcok_s2 = r.dcok_s1;
    next_r.sack_s1 = sack_in;
    next_r.sack_s2 = r.sack_s1;
    clr_all = !r.dcok_s2 || io_reset_register_write_in;
    // No-response timer on a processor bus cycle
    resp_to = evt_in.wait_resp && (r.resp_cnt == BEEL_TMR_W'(BEEL_RESP_CYC - 1));
    next_r.resp_cnt = evt_in.wait_resp && !resp_to ? r.resp_cnt + 1'b1 : '0;
    // Grant wait timer on a demand read
    grant_to = evt_in.wait_grant && (r.grant_cnt == BEEL_TMR_W'(GRANT_CYC - 1));
    next_r.grant_cnt = evt_in.wait_grant && !grant_to ? r.grant_cnt + 1'b1 : '0;
    // Master side errors
    if (resp_to)
    begin
      case (evt_in.kind)
        BEEL_K_DEMAND:
        begin
          do_abort = 1'b1;
          do_mcheck = 1'b1;
          m_evt = 1'b1;
          m_capture = 1'b1;
        end
        BEEL_K_PREFETCH, BEEL_K_VECTOR: do_abort = 1'b1;
        BEEL_K_WRITE:
        begin
          m_evt = 1'b1;
          do_irq = 1'b1;
        end
        default: ;
      endcase
    end
    if (m_evt)
      set_bits[BEEL_ST_TIMEOUT] = 1'b1;
    if (evt_in.parity)
    begin
      case (evt_in.kind)
        BEEL_K_DEMAND:
        begin
          do_abort = 1'b1;
          do_mcheck = 1'b1;
          set_bits[BEEL_ST_PARITY] = 1'b1;
          m_evt = 1'b1;
          m_capture = 1'b1;
        end
        BEEL_K_PREFETCH: do_abort = 1'b1;
        default: ;
      endcase
    end
    // First master error wins; a later one only marks loss
    if (m_evt && (r.status[BEEL_ST_PARITY] || r.status[BEEL_ST_TIMEOUT]))
    begin
      set_bits[BEEL_ST_LOST] = 1'b1;
      set_bits[BEEL_ST_PARITY] = 1'b0;
      set_bits[BEEL_ST_TIMEOUT] = 1'b0;
    end
    else if (m_capture)
      next_r.mpage = evt_in.bus_addr[BEEL_MADDR_HI:BEEL_MADDR_LO];
    // Demand read without grant
    if (grant_to && evt_in.kind == BEEL_K_DEMAND)
    begin
      do_abort = 1'b1;
      do_mcheck = 1'b1;
      set_bits[BEEL_ST_NO_GRANT] = 1'b1;
    end
    // Multiple longword to bus space
    if (evt_in.multi_lw)
    begin
      do_abort = 1'b1;
      do_mcheck = 1'b1;
    end
    // Local memory side errors
    if (evt_in.mem_err || evt_in.nxm)
    begin
      case (evt_in.kind)
        BEEL_K_LOCK:
        begin
          do_abort = 1'b1;
          do_mcheck = 1'b1;
          next_r.resp.lock_release = 1'b1;
          next_r.resp.bus_release = 1'b1;
        end
        BEEL_K_MAP_RD:
        begin
          do_abort = 1'b1;
          do_mcheck = 1'b1;
        end
        BEEL_K_LMGH_RD:
        begin
          do_abort = 1'b1;
          do_mcheck = 1'b1;
        end
        BEEL_K_DMA_RD:
          if (evt_in.mem_err)
            next_r.resp.bus_data_lines_par = BEEL_BUS_PARITY;
          else
            do_irq = 1'b1;
        BEEL_K_MAP_WR, BEEL_K_DMA_WR, BEEL_K_LMGH_WR: do_irq = 1'b1;
        default: ;
      endcase
      s_evt = slave_logs(evt_in.kind);
    end
    if (s_evt)
    begin
      set_bits[BEEL_ST_MEM_ERR] = evt_in.mem_err;
      set_bits[BEEL_ST_SLV_NXM] = evt_in.nxm && !evt_in.mem_err;
      if (r.status[BEEL_ST_MEM_ERR] || r.status[BEEL_ST_SLV_NXM])
        set_bits[BEEL_ST_LOST] = 1'b1;
      else
        next_r.spage = evt_in.map_addr[BEEL_SADDR_HI:BEEL_SADDR_LO];
    end
    // Register port: status on any width, pages read only
    next_r.ack = reg_rd_in || reg_wr_in;
    next_r.rdata = '0;
    if (reg_wr_in && hit(BEEL_ADDR_STATUS, reg_addr_in) && reg_be_in[0])
      clr_bits = reg_wdata_in[BEEL_ST_W-1:0];
    if (reg_wr_in && (hit(BEEL_ADDR_MPAGE, reg_addr_in) || hit(BEEL_ADDR_SPAGE, reg_addr_in)))
      do_mcheck = 1'b1;
    if (reg_rd_in)
    begin
      if (hit(BEEL_ADDR_STATUS, reg_addr_in))
        next_r.rdata = {{(32 - BEEL_ST_W){1'b0}}, r.status};
      else if (hit(BEEL_ADDR_MPAGE, reg_addr_in))
        next_r.rdata = {{(32 - BEEL_MPAGE_W){1'b0}}, r.mpage};
      else if (hit(BEEL_ADDR_SPAGE, reg_addr_in))
        next_r.rdata = {{(32 - BEEL_SPAGE_W){1'b0}}, r.spage};
    end
    // Status update: an event in the same cycle beats its clear
    next_r.status = (r.status & ~clr_bits) | set_bits;
    // Memory error copy in the interprocessor register
    if (next_r.status[BEEL_ST_MEM_ERR] || next_r.status[BEEL_ST_SLV_NXM])
      next_r.ip_mem_err = 1'b1;
    else if (clr_bits[BEEL_ST_MEM_ERR])
      next_r.ip_mem_err = 1'b0;
    // One-cycle responses, interrupt held until acknowledged
    next_r.resp.abort = do_abort;
    next_r.resp.mcheck = do_mcheck;
    if (!(evt_in.mem_err || evt_in.nxm) || evt_in.kind != BEEL_K_LOCK)
    begin
      next_r.resp.lock_release = 1'b0;
      next_r.resp.bus_release = 1'b0;
    end
    if (!(evt_in.mem_err && evt_in.kind == BEEL_K_DMA_RD))
      next_r.resp.bus_data_lines_par = '0;
    next_r.resp.irq_req = do_irq || (r.resp.irq_req && !irq_ack_in);
    next_r.resp.irq_level = BEEL_IRQ_LEVEL;
    next_r.resp.irq_vector = BEEL_IRQ_VECTOR;
    // Arbiter: withdraw a grant that is never acknowledged
    next_r.arb_cnt = '0;
    case (r.arb)
      BEEL_A_IDLE:
        if (arb_req_in)
          next_r.arb = BEEL_A_GRANT;
      BEEL_A_GRANT:
        if (r.sack_s2)
          next_r.arb = BEEL_A_BUSY;
        else if (r.arb_cnt == BEEL_ARB_W'(BEEL_SACK_CYC - 1))
          next_r.arb = BEEL_A_HOLD;
        else
          next_r.arb_cnt = r.arb_cnt + 1'b1;
      BEEL_A_BUSY:
        if (!r.sack_s2)
          next_r.arb = BEEL_A_IDLE;
      BEEL_A_HOLD:
        if (r.arb_cnt == BEEL_ARB_W'(BEEL_HOLD_CYC - 1))
          next_r.arb = BEEL_A_IDLE;
        else
          next_r.arb_cnt = r.arb_cnt + 1'b1;
      default: next_r.arb = BEEL_A_IDLE;
    endcase
    // Power-up, DCOK and IO reset clear the log
    if (clr_all)
    begin
      next_r.status = '0;
      next_r.ip_mem_err = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      r <= '0;
      r.arb <= BEEL_A_IDLE;
      r.resp.irq_level <= BEEL_IRQ_LEVEL;
      r.resp.irq_vector <= BEEL_IRQ_VECTOR;
    end
    else
      r <= next_r;
  end

  // Outputs straight from state
  assign reg_rdata_out = r.rdata;
  assign reg_ack_out = r.ack;
  assign resp_out = r.resp;
  assign interprocessor_register_mem_err_out = r.ip_mem_err;
  assign grant_out = r.arb == BEEL_A_GRANT;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_clear_on_io_reset;
    io_reset_register_write_in |=> (r.status == '0);
  endproperty
  a_clear_on_io_reset: assert property (p_clear_on_io_reset) else $error("status not cleared");

  property p_w1c;
    reg_wr_in && hit(BEEL_ADDR_STATUS, reg_addr_in) && reg_be_in[0] && reg_wdata_in[BEEL_ST_LOST]
      && !set_bits[BEEL_ST_LOST] && !clr_all |=> !r.status[BEEL_ST_LOST];
  endproperty
  a_w1c: assert property (p_w1c) else $error("lost bit not cleared by one");

  property p_sticky;
    r.status[BEEL_ST_PARITY] && !clr_bits[BEEL_ST_PARITY] && !clr_all
      |=> r.status[BEEL_ST_PARITY];
  endproperty
  a_sticky: assert property (p_sticky) else $error("parity bit dropped");

  property p_mpage_hold;
    (r.status[BEEL_ST_PARITY] || r.status[BEEL_ST_TIMEOUT]) && m_evt && !clr_all
      |=> $stable(r.mpage) && r.status[BEEL_ST_LOST];
  endproperty
  a_mpage_hold: assert property (p_mpage_hold) else $error("master page overwritten");

  property p_ro_write;
    reg_wr_in && hit(BEEL_ADDR_SPAGE, reg_addr_in) |=> resp_out.mcheck;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("no check on page write");

  property p_spage_hold;
    (r.status[BEEL_ST_MEM_ERR] || r.status[BEEL_ST_SLV_NXM]) |=> $stable(r.spage);
  endproperty
  a_spage_hold: assert property (p_spage_hold) else $error("slave page changed while held");

  property p_resp_timeout;
    evt_in.wait_resp && evt_in.kind == BEEL_K_DEMAND
      && r.resp_cnt == BEEL_TMR_W'(BEEL_RESP_CYC - 1)
      |=> resp_out.abort && resp_out.mcheck;
  endproperty
  a_resp_timeout: assert property (p_resp_timeout) else $error("demand read never aborted");

  property p_write_irq;
    resp_to && evt_in.kind == BEEL_K_WRITE && !clr_all
      |=> resp_out.irq_req && r.status[BEEL_ST_TIMEOUT];
  endproperty
  a_write_irq: assert property (p_write_irq) else $error("write timeout not reported");

  property p_dma_rd_par;
    evt_in.mem_err && evt_in.kind == BEEL_K_DMA_RD
      |=> resp_out.bus_data_lines_par == BEEL_BUS_PARITY && !resp_out.mcheck;
  endproperty
  a_dma_rd_par: assert property (p_dma_rd_par) else $error("no bus parity on DMA read");

  property p_sack_withdraw;
    grant_out && !r.sack_s2 && r.arb_cnt == BEEL_ARB_W'(BEEL_SACK_CYC - 1)
      |=> !grant_out [*8];
  endproperty
  a_sack_withdraw: assert property (p_sack_withdraw) else $error("grant not withdrawn");

  property p_ip_flag;
    r.status[BEEL_ST_MEM_ERR] |-> r.ip_mem_err;
  endproperty
  a_ip_flag: assert property (p_ip_flag) else $error("memory error copy missing");

  c_master_log: cover property (m_capture ##1 r.status[BEEL_ST_PARITY]);
  c_lost: cover property (r.status[BEEL_ST_LOST]);
  c_withdraw: cover property (r.arb == BEEL_A_HOLD);
  c_dma_irq: cover property (s_evt && do_irq);

endmodule // beel_error_log

// *** verilog/beel_pkg.sv ***
// Constants, codes and carrier types for the bus interface error log.
// Assumes one 100 MHz module clock and event strobes from the bus
// interface logic on that same clock.
// Summary of operation
// - Status clears on reset, DCOK low, IO reset
// - Events set bits; write one clears
// - Status takes byte, word, longword access
// - Master page captures address 21:9, upper zero
// - Master page valid only with parity/timeout
// - Repeat master error sets lost bit
// - Writing either page register raises machine check
// - Slave page captures address 28:9, upper zero
// - Slave page holds until both bits cleared
// - Demand read timeout: abort, check, flag, capture
// - Write timeout sets bit 7, interrupt 1D/60
// - Read-lock error aborts, releases lock and bus
// - Multi-longword to bus space aborts with check
// - No grant in 10ms: abort, check, flag
// - Demand read parity: abort, check, flag, capture
// - Map write error interrupts; map read checks
// - DMA nonexistent memory: bit 0, interrupt, capture
// - DMA read error: capture, flags, bus parity
// - DMA write error interrupts, master not told
// - No acknowledge in 10us: withdraw, wait 500ns
// - Remote demand read error: check, capture, bit
// - Remote write error: interrupt, capture, bit
// - Memory error flag follows bits 4/0, clears
package beel_pkg;
  // Register byte addresses
  localparam logic [31:0] BEEL_ADDR_STATUS = 32'h2008_0004;
  localparam logic [31:0] BEEL_ADDR_MPAGE = 32'h2008_0008;
  localparam logic [31:0] BEEL_ADDR_SPAGE = 32'h2008_000C;
  localparam logic [3:0] BEEL_BE_LONG = 4'hF;
  // Status bit positions
  localparam int BEEL_ST_SLV_NXM = 0;
  localparam int BEEL_ST_NO_GRANT = 2;
  localparam int BEEL_ST_LOST = 3;
  localparam int BEEL_ST_MEM_ERR = 4;
  localparam int BEEL_ST_PARITY = 5;
  localparam int BEEL_ST_TIMEOUT = 7;
  localparam int BEEL_ST_W = 8;
  // Address capture fields
  localparam int BEEL_MADDR_LO = 9;
  localparam int BEEL_MADDR_HI = 21;
  localparam int BEEL_SADDR_LO = 9;
  localparam int BEEL_SADDR_HI = 28;
  localparam int BEEL_MPAGE_W = BEEL_MADDR_HI - BEEL_MADDR_LO + 1;
  localparam int BEEL_SPAGE_W = BEEL_SADDR_HI - BEEL_SADDR_LO + 1;
  // Interrupt identity
  localparam logic [4:0] BEEL_IRQ_LEVEL = 5'h1D;
  localparam logic [8:0] BEEL_IRQ_VECTOR = 9'h060;
  localparam logic [1:0] BEEL_BUS_PARITY = 2'h3;
  // Timing
  localparam int BEEL_CLK_NS = 10;
  localparam int BEEL_RESP_TO_NS = 10000;
  localparam int BEEL_GRANT_TO_MS = 10;
  localparam int BEEL_SACK_TO_NS = 10000;
  localparam int BEEL_HOLDOFF_NS = 500;
  localparam int BEEL_RESP_CYC = BEEL_RESP_TO_NS / BEEL_CLK_NS;
  localparam int BEEL_GRANT_CYC = BEEL_GRANT_TO_MS * 1000000 / BEEL_CLK_NS;
  localparam int BEEL_SACK_CYC = BEEL_SACK_TO_NS / BEEL_CLK_NS;
  localparam int BEEL_HOLD_CYC = (BEEL_HOLDOFF_NS + BEEL_CLK_NS - 1) / BEEL_CLK_NS;
  localparam int BEEL_TMR_W = 20;
  localparam int BEEL_ARB_W = 11;
  // Reference kinds of the cycle in which an error arrives
  typedef enum logic [3:0] {
    BEEL_K_NONE = 4'h0, BEEL_K_DEMAND = 4'h1, BEEL_K_PREFETCH = 4'h2,
    BEEL_K_VECTOR = 4'h3, BEEL_K_WRITE = 4'h4, BEEL_K_LOCK = 4'h5,
    BEEL_K_MAP_RD = 4'h6, BEEL_K_MAP_WR = 4'h7, BEEL_K_DMA_RD = 4'h8,
    BEEL_K_DMA_WR = 4'h9, BEEL_K_LMGH_RD = 4'hA, BEEL_K_LMGH_WR = 4'hB
  } beel_kind_type;
  // Arbiter grant states
  typedef enum logic [3:0] {
    BEEL_A_IDLE = 4'b0001, BEEL_A_GRANT = 4'b0010,
    BEEL_A_BUSY = 4'b0100, BEEL_A_HOLD = 4'b1000
  } beel_arb_type;
  // Error strobes from the bus interface
  typedef struct packed {
    beel_kind_type kind;
    logic parity;
    logic mem_err;
    logic nxm;
    logic multi_lw;
    logic wait_resp;
    logic wait_grant;
    logic [BEEL_MADDR_HI:0] bus_addr;
    logic [BEEL_SADDR_HI:0] map_addr;
  } beel_evt_type;
  // Responses to the processor and bus
  typedef struct packed {
    logic abort;
    logic mcheck;
    logic lock_release;
    logic bus_release;
    logic irq_req;
    logic [4:0] irq_level;
    logic [8:0] irq_vector;
    logic [1:0] bus_data_lines_par;
  } beel_resp_type;
endpackage : beel_pkg
